/* logic/dsw_pkg.sv */
// Shared constants for the strobe, differential and warmup controller.
package dsw_pkg;

    // Register bus geometry.
    localparam int DSW_ADDR_W = 4;
    localparam int DSW_DATA_W = 32;

    // Register byte offsets.
    localparam logic [3:0] DSW_OFF_CFG = 4'h0;
    localparam logic [3:0] DSW_OFF_CMD = 4'h4;
    localparam logic [3:0] DSW_OFF_STAT = 4'h8;
    localparam logic [3:0] DSW_OFF_CAP = 4'hC;

    // Configuration register field positions.
    localparam int DSW_CFG_MODE_LSB = 0;
    localparam int DSW_CFG_DIFF_RE = 2;
    localparam int DSW_CFG_DIFF_DQS = 3;
    localparam int DSW_CFG_OWARM_LSB = 4;
    localparam int DSW_CFG_IWARM_LSB = 8;

    // Command register bits, each a write-one pulse.
    localparam int DSW_CMD_FULL_RST = 0;
    localparam int DSW_CMD_SYNC_RST = 1;
    localparam int DSW_CMD_LUN_RST = 2;

    // Width of a warmup count field and of a data byte.
    localparam int DSW_WARM_W = 4;
    localparam int DSW_BYTE_W = 8;

    // Data interface selection codes.
    localparam logic [1:0] DSW_MODE_SINGLE = 2'h0;
    localparam logic [1:0] DSW_MODE_VAR_A = 2'h1;
    localparam logic [1:0] DSW_MODE_VAR_B = 2'h2;
    localparam logic [1:0] DSW_MODE_BAD = 2'h3;

    // Values after reset.
    localparam logic [1:0] DSW_MODE_RST = DSW_MODE_SINGLE;
    localparam logic [3:0] DSW_WARM_RST = 4'h0;
    localparam logic DSW_DIFF_RST = 1'b0;

    // Bit positions in the synchronised pin vector.
    localparam int DSW_PIN_W = 16;
    localparam int DSW_PIN_CE_N = 15;
    localparam int DSW_PIN_CLE = 14;
    localparam int DSW_PIN_ALE = 13;
    localparam int DSW_PIN_WE_N = 12;
    localparam int DSW_PIN_RS_T = 11;
    localparam int DSW_PIN_RS_C = 10;
    localparam int DSW_PIN_DQS_T = 9;
    localparam int DSW_PIN_DQS_C = 8;
    localparam int DSW_PIN_DQ_LSB = 0;

    // Burst tracking states.
    typedef enum logic [1:0] {
        DSW_ST_IDLE,
        DSW_ST_OUT,
        DSW_ST_IN
    } dsw_burst_t;

endpackage

/* logic/dsw_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for a vector of pin levels.
module dsw_sync #(
    parameter int W = 16
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Raw pins and their synchronised levels.
    input wire logic [W-1:0] raw,
    output logic [W-1:0] level
);
    // Both stages live in one state word; only the second stage is read outside.
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dsw_sync_st_t;

    dsw_sync_st_t st_q;
    dsw_sync_st_t st_d;

    // Shift the pins through the two stages.
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = raw;
        st_d.s2 = st_q.s1;
    end

    // Register the stages.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // The second stage is the only safe level to use.
    assign level = st_q.s2;
endmodule
`default_nettype wire

/* logic/dsw_warm_cnt.sv */
`timescale 1ns/1ps
`default_nettype none
// Counts the strobe edges of one burst's warmup phase.
module dsw_warm_cnt #(
    parameter int CNT_W = 4
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Burst start, per-edge step and abort.
    input wire logic start,
    input wire logic step,
    input wire logic clear,
    // Configured number of full warmup cycles.
    input wire logic [CNT_W-1:0] cycles,
    // High while warmup edges remain after the current one.
    output logic busy
);
    // Remaining edges; each warmup cycle is two edges.
    typedef struct packed {
        logic [CNT_W:0] left;
    } dsw_warm_st_t;

    dsw_warm_st_t st_q;
    dsw_warm_st_t st_d;

    // The start edge is itself the first warmup edge, so load one less.
    always_comb
    begin
        st_d = st_q;
        if (clear)
        begin
            st_d.left = '0;
        end
        else if (start)
        begin
            // A zero count means no warmup at all.
            st_d.left = (cycles == '0) ? '0 : (CNT_W + 1)'({cycles, 1'b0} - 1'b1);
        end
        else if (step && (st_q.left != '0))
        begin
            st_d.left = st_q.left - 1'b1;
        end
    end

    // Register the count.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign busy = (st_q.left != '0);
endmodule
`default_nettype wire

/* logic/dsw_ctrl.sv */
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Differential pairs only in double-rate modes.
// - Capability register advertises complementary signal support.
// - Differential signaling off after reset.
// - Separate enables for read and data strobe.
// - Complement active only if double-rate and enabled.
// - Variant A full reset clears differential enables.
// - Variant B full reset keeps differential enables.
// - Sync and unit resets keep differential enables.
// - Output warmup toggles strobe, drives no data.
// - Each warmup cycle is rising plus falling.
// - Input warmup strobe cycles: data lines ignored.
// - Independent warmup counts for output and input.
// - Warmup applies to every command in double-rate.
// - Warmup at start of every enabled burst.
// - Latch or chip enable rising ends burst.
// - New warmup setting applies to following commands.
module dsw_ctrl
    import dsw_pkg::*;
#(
    parameter bit SUP_RE_COMP = 1'b1,
    parameter bit SUP_DQS_COMP = 1'b1
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Avalon-MM register slave.
    input wire logic [dsw_pkg::DSW_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [dsw_pkg::DSW_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [dsw_pkg::DSW_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Control pins driven by the host.
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic read_strobe_true,
    input wire logic read_strobe_comp,
    // Data strobe pair, two-way.
    input wire logic data_strobe_true,
    output logic data_strobe_true_drive,
    output logic data_strobe_true_oe,
    input wire logic data_strobe_comp,
    output logic data_strobe_comp_drive,
    output logic data_strobe_comp_oe,
    // Data bus, two-way.
    input wire logic [dsw_pkg::DSW_BYTE_W-1:0] data_bus,
    output logic [dsw_pkg::DSW_BYTE_W-1:0] data_bus_drive,
    output logic data_bus_oe,
    // Byte stream toward the array side.
    input wire logic [dsw_pkg::DSW_BYTE_W-1:0] out_byte,
    output logic out_take,
    output logic [dsw_pkg::DSW_BYTE_W-1:0] in_byte,
    output logic in_valid,
    // Live differential status.
    output logic read_strobe_comp_active,
    output logic data_strobe_comp_active
);
    import dsw_pkg::*;
    // State of the controller apart from the synchroniser and the warmup counters.
    typedef struct packed {
        dsw_burst_t burst;
        logic [1:0] mode;
        logic diff_re_en;
        logic diff_dqs_en;
        logic [DSW_WARM_W-1:0] owarm;
        logic [DSW_WARM_W-1:0] iwarm;
        logic [2:0] ctl_prev;
        logic we_prev;
        logic rs_lvl;
        logic dqsi_lvl;
        logic bus_wait;
        logic [DSW_DATA_W-1:0] rdata;
        logic dqs_drv;
        logic dqs_oe;
        logic dqs_comp_drv;
        logic dqs_comp_oe;
        logic [DSW_BYTE_W-1:0] dq_drv;
        logic dq_oe;
        logic [DSW_BYTE_W-1:0] in_byte;
        logic in_valid;
        logic out_take;
        logic re_act;
        logic dqs_act;
    } dsw_ctrl_st_t;
    dsw_ctrl_st_t st_q;
    dsw_ctrl_st_t st_d;
    // Synchronised pins and helper terms.
    logic [DSW_PIN_W-1:0] pin;
    logic [2:0] ctl_now;
    logic bus_req, cfg_wr, cmd_wr, full_rst, soft_rst, ddr, link_sel, end_evt;
    logic rs_next, dqsi_next, rs_edge, dqsi_edge, we_rise;
    logic start_o, start_i, out_ev, in_ev, warm_o, warm_i, o_busy, i_busy, cnt_clear;
    logic [DSW_DATA_W-1:0] cfg_word, cfg_new, rd_val;
    // Every pin from the host crosses two flops before any use.
    dsw_sync #(.W(DSW_PIN_W)) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .raw({ce_n, cle, ale, we_n, read_strobe_true, read_strobe_comp,
              data_strobe_true, data_strobe_comp, data_bus}),
        .level(pin)
    );
    // Output and input warmup are counted apart, each with its own length.
    dsw_warm_cnt #(.CNT_W(DSW_WARM_W)) u_warm_out (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .start(start_o),
        .step(out_ev),
        .clear(cnt_clear),
        .cycles(st_q.owarm),
        .busy(o_busy)
    );
    dsw_warm_cnt #(.CNT_W(DSW_WARM_W)) u_warm_in (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .start(start_i),
        .step(in_ev),
        .clear(cnt_clear),
        .cycles(st_q.iwarm),
        .busy(i_busy)
    );
    // Next-state logic: bus slave, configuration, burst tracking and strobes.
    always_comb
    begin
        st_d = st_q;
        st_d.out_take = 1'b0;
        st_d.in_valid = 1'b0;
        start_o = 1'b0;
        start_i = 1'b0;
        // The configuration word as software sees it; unused bits read zero.
        cfg_word = '0;
        cfg_word[DSW_CFG_MODE_LSB +: 2] = st_q.mode;
        cfg_word[DSW_CFG_DIFF_RE] = st_q.diff_re_en;
        cfg_word[DSW_CFG_DIFF_DQS] = st_q.diff_dqs_en;
        cfg_word[DSW_CFG_OWARM_LSB +: DSW_WARM_W] = st_q.owarm;
        cfg_word[DSW_CFG_IWARM_LSB +: DSW_WARM_W] = st_q.iwarm;
        // Merge write data into the configuration word by byte lane.
        cfg_new = cfg_word;
        for (int b = 0; b < 4; b++)
        begin
            if (avs_byteenable[b])
            begin
                cfg_new[8*b +: 8] = avs_writedata[8*b +: 8];
            end
        end
        // One wait cycle per access; the access completes when wait is low.
        bus_req = avs_read | avs_write;
        st_d.bus_wait = ~(bus_req & st_q.bus_wait);
        cfg_wr = avs_write & ~st_q.bus_wait & (avs_address == DSW_OFF_CFG);
        cmd_wr = avs_write & ~st_q.bus_wait & (avs_address == DSW_OFF_CMD) & avs_byteenable[0];
        full_rst = cmd_wr & avs_writedata[DSW_CMD_FULL_RST];
        soft_rst = cmd_wr & (avs_writedata[DSW_CMD_SYNC_RST] | avs_writedata[DSW_CMD_LUN_RST]);
        // Read mux; unmapped offsets and the command register read zero.
        case (avs_address)
            DSW_OFF_CFG: rd_val = cfg_word;
            DSW_OFF_STAT: rd_val = {26'h0, o_busy, i_busy, st_q.burst, st_q.dqs_act, st_q.re_act};
            DSW_OFF_CAP: rd_val = {30'h0, SUP_DQS_COMP, SUP_RE_COMP};
            default: rd_val = '0;
        endcase
        if (bus_req && st_q.bus_wait)
        begin
            st_d.rdata = rd_val;
        end
        // Configuration write; a reserved mode code leaves the mode alone.
        // Counts written here are picked up at the next burst start.
        if (cfg_wr)
        begin
            if (cfg_new[DSW_CFG_MODE_LSB +: 2] != DSW_MODE_BAD)
            begin
                st_d.mode = cfg_new[DSW_CFG_MODE_LSB +: 2];
            end
            // An enable sticks only where the pin pair is supported.
            st_d.diff_re_en = cfg_new[DSW_CFG_DIFF_RE] & SUP_RE_COMP;
            st_d.diff_dqs_en = cfg_new[DSW_CFG_DIFF_DQS] & SUP_DQS_COMP;
            st_d.owarm = cfg_new[DSW_CFG_OWARM_LSB +: DSW_WARM_W];
            st_d.iwarm = cfg_new[DSW_CFG_IWARM_LSB +: DSW_WARM_W];
        end
        // A full reset drops the enables only in variant A; sync and unit resets never do.
        if (full_rst && (st_q.mode == DSW_MODE_VAR_A))
        begin
            st_d.diff_re_en = DSW_DIFF_RST;
            st_d.diff_dqs_en = DSW_DIFF_RST;
        end
        // Complements count only in a double-rate mode with the enable set.
        st_d.re_act = (st_d.mode != DSW_MODE_SINGLE) & st_d.diff_re_en;
        st_d.dqs_act = (st_d.mode != DSW_MODE_SINGLE) & st_d.diff_dqs_en;
        // Pin levels; an active differential pair moves only when its two halves differ.
        ddr = (st_q.mode != DSW_MODE_SINGLE);
        ctl_now = {pin[DSW_PIN_CE_N], pin[DSW_PIN_CLE], pin[DSW_PIN_ALE]};
        link_sel = (ctl_now == 3'h0);
        end_evt = |(ctl_now & ~st_q.ctl_prev);
        we_rise = pin[DSW_PIN_WE_N] & ~st_q.we_prev;
        rs_next = pin[DSW_PIN_RS_T];
        if (st_q.re_act && (pin[DSW_PIN_RS_T] == pin[DSW_PIN_RS_C]))
        begin
            rs_next = st_q.rs_lvl;
        end
        dqsi_next = pin[DSW_PIN_DQS_T];
        if (st_q.dqs_act && (pin[DSW_PIN_DQS_T] == pin[DSW_PIN_DQS_C]))
        begin
            dqsi_next = st_q.dqsi_lvl;
        end
        rs_edge = rs_next ^ st_q.rs_lvl;
        dqsi_edge = (dqsi_next ^ st_q.dqsi_lvl) & ~st_q.dqs_oe;
        st_d.rs_lvl = rs_next;
        st_d.dqsi_lvl = dqsi_next;
        st_d.ctl_prev = ctl_now;
        st_d.we_prev = pin[DSW_PIN_WE_N];
        // Burst entry; warmup is armed on every double-rate burst, any command.
        case (st_q.burst)
            DSW_ST_IDLE:
            begin
                if (link_sel && rs_edge)
                begin
                    st_d.burst = DSW_ST_OUT;
                    start_o = ddr;
                end
                else if (link_sel && (ddr ? dqsi_edge : we_rise))
                begin
                    st_d.burst = DSW_ST_IN;
                    start_i = ddr;
                end
            end
            DSW_ST_OUT, DSW_ST_IN: st_d.burst = st_q.burst;
            default: st_d.burst = DSW_ST_IDLE;
        endcase
        // A rising latch or chip enable closes the burst; a pause alone does not.
        cnt_clear = end_evt | full_rst | soft_rst;
        if (cnt_clear)
        begin
            st_d.burst = DSW_ST_IDLE;
            start_o = 1'b0;
            start_i = 1'b0;
        end
        // Output burst: double rate uses both edges, single rate the rising one.
        out_ev = rs_edge & (st_d.burst == DSW_ST_OUT) & (ddr | rs_next);
        warm_o = start_o ? (st_q.owarm != '0) : o_busy;
        if (out_ev)
        begin
            if (warm_o)
            begin
                // Warmup edges carry no data, so the bus stays released.
                st_d.dq_oe = 1'b0;
            end
            else
            begin
                st_d.dq_oe = 1'b1;
                st_d.dq_drv = out_byte;
                st_d.out_take = 1'b1;
            end
        end
        // In double rate the data strobe mirrors the read strobe through warmup and data.
        st_d.dqs_oe = (st_d.burst == DSW_ST_OUT) & ddr;
        st_d.dqs_drv = st_d.dqs_oe & rs_next;
        st_d.dqs_comp_oe = st_d.dqs_oe & st_d.dqs_act;
        st_d.dqs_comp_drv = st_d.dqs_comp_oe & ~rs_next;
        if (st_d.burst != DSW_ST_OUT)
        begin
            st_d.dq_oe = 1'b0;
        end
        // Input burst: bytes on strobe edges once warmup is spent.
        in_ev = (st_d.burst == DSW_ST_IN) & (ddr ? dqsi_edge : we_rise);
        warm_i = start_i ? (st_q.iwarm != '0) : i_busy;
        if (in_ev && !warm_i)
        begin
            st_d.in_byte = pin[DSW_PIN_DQ_LSB +: DSW_BYTE_W];
            st_d.in_valid = 1'b1;
        end
    end
    // Register the state; every output below is read straight from it.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st_q <= '0;
            st_q.mode <= DSW_MODE_RST;
            st_q.diff_re_en <= DSW_DIFF_RST;
            st_q.diff_dqs_en <= DSW_DIFF_RST;
            st_q.owarm <= DSW_WARM_RST;
            st_q.iwarm <= DSW_WARM_RST;
            st_q.bus_wait <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end
    // Port drivers.
    assign avs_readdata = st_q.rdata;
    assign avs_waitrequest = st_q.bus_wait;
    assign data_strobe_true_drive = st_q.dqs_drv;
    assign data_strobe_true_oe = st_q.dqs_oe;
    assign data_strobe_comp_drive = st_q.dqs_comp_drv;
    assign data_strobe_comp_oe = st_q.dqs_comp_oe;
    assign data_bus_drive = st_q.dq_drv;
    assign data_bus_oe = st_q.dq_oe;
    assign out_take = st_q.out_take;
    assign in_byte = st_q.in_byte;
    assign in_valid = st_q.in_valid;
    assign read_strobe_comp_active = st_q.re_act;
    assign data_strobe_comp_active = st_q.dqs_act;
    // Checks on the controller's own behaviour.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    diff_mode_gate_a: assert property (st_q.re_act == ((st_q.mode != DSW_MODE_SINGLE) && st_q.diff_re_en))
        else $error("read strobe complement active outside its conditions");
    diff_single_off_a: assert property ((st_q.mode == DSW_MODE_SINGLE) |-> !st_q.dqs_act && !st_q.dqs_comp_oe)
        else $error("differential strobe active in single rate mode");
    cap_gate_a: assert property ((st_q.diff_re_en |-> SUP_RE_COMP) and (st_q.diff_dqs_en |-> SUP_DQS_COMP))
        else $error("enable set for an unsupported pair");
    reset_off_a: assert property ($past(sys_rst) |-> !st_q.diff_re_en && !st_q.diff_dqs_en)
        else $error("differential enabled right after reset");
    var_a_clear_a: assert property (full_rst && st_q.mode == DSW_MODE_VAR_A |=> !st_q.diff_re_en && !st_q.diff_dqs_en)
        else $error("full reset did not clear enables in variant A");
    var_b_keep_a: assert property (full_rst && st_q.mode == DSW_MODE_VAR_B |=> $stable({st_q.diff_re_en, st_q.diff_dqs_en}))
        else $error("full reset changed enables in variant B");
    soft_keep_a: assert property (soft_rst && !full_rst |=> $stable({st_q.diff_re_en, st_q.diff_dqs_en}))
        else $error("soft reset changed differential enables");
    out_warm_quiet_a: assert property (out_ev && warm_o |=> !st_q.dq_oe && !st_q.out_take)
        else $error("data driven during output warmup");
    in_warm_ignore_a: assert property (in_ev && warm_i |=> !st_q.in_valid)
        else $error("byte accepted during input warmup");
    strobe_follow_a: assert property (st_q.dqs_oe |-> st_q.dqs_drv == st_q.rs_lvl)
        else $error("data strobe does not follow read strobe");
    burst_end_a: assert property (end_evt |=> st_q.burst == DSW_ST_IDLE && !st_q.dq_oe ##1 !st_q.dqs_oe || st_q.burst != DSW_ST_IDLE)
        else $error("burst not closed by control rise");
    zero_warm_a: assert property (start_o && st_q.owarm == '0 |=> st_q.out_take)
        else $error("zero warmup count still delayed data");
    out_warm_burst_c: cover property (start_o && st_q.owarm != '0 ##[1:200] st_q.out_take);
    in_warm_burst_c: cover property (start_i && st_q.iwarm != '0 ##[1:200] st_q.in_valid);
    full_rst_b_c: cover property (full_rst && st_q.mode == DSW_MODE_VAR_B && st_q.diff_dqs_en);
endmodule
`default_nettype wire

/* tb/dsw_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host model: control pins, read strobe pair, and the data strobe and data in input bursts.
module dsw_host (
    // Clock shared with the bench.
    input wire logic sys_clk,
    // Control and read strobe pins.
    output logic ce_n,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic rs_t,
    output logic rs_c,
    // Data strobe and data bus, driven only in input bursts.
    output logic dqs_t,
    output logic dqs_oe,
    output logic [7:0] dq,
    output logic dq_oe
);
    // Idle levels; chip enable rests high so every setting change is followed by a deselect.
    initial
    begin
        ce_n = 1'b1;
        cle = 1'b0;
        ale = 1'b0;
        we_n = 1'b1;
        rs_t = 1'b1;
        rs_c = 1'b0;
        dqs_t = 1'b0;
        dqs_oe = 1'b0;
        dq = 8'h00;
        dq_oe = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Output burst; a pause keeps the burst open, so no fresh warmup is sent after it.
    task automatic out_burst(input int edges, input int pause_at);
        ce_n <= 1'b0;
        wait_clk(4);
        for (int i = 0; i < edges; i++)
        begin
            rs_t <= ~rs_t;
            rs_c <= rs_t;
            wait_clk((i == pause_at) ? 24 : 4);
        end
        ce_n <= 1'b1;
        wait_clk(8);
    endtask

    // Input burst; the strobe is taken before chip enable falls so no stray edge opens it.
    task automatic in_burst(input int edges, input logic [7:0] first);
        dqs_oe <= 1'b1;
        dq_oe <= 1'b1;
        wait_clk(4);
        ce_n <= 1'b0;
        wait_clk(4);
        for (int i = 0; i < edges; i++)
        begin
            dq <= first + 8'(i);
            wait_clk(2);
            dqs_t <= ~dqs_t;
            wait_clk(2);
        end
        ce_n <= 1'b1;
        wait_clk(4);
        dqs_oe <= 1'b0;
        dq_oe <= 1'b0;
        wait_clk(4);
    endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dsw_pkg::*;
    logic sys_clk, sys_rst, avs_read, avs_write, prev_s;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic avs_waitrequest, dqs_t_drv, dqs_t_oe, dqs_c_drv, dqs_c_oe, dq_oe_d, out_take, in_valid;
    logic [7:0] dq_drv, out_byte, in_byte, first_in, first;
    logic ce_n, cle, ale, we_n, rs_t, rs_c, h_dqs, h_dqs_oe, h_dq_oe, rc_act, dc_act;
    logic [7:0] h_dq;
    int err_count, tests_run, takes, valids, tog, ow, iw, nd, md, de;
    // Wire levels; a released bus shows the inverse of the host's last data so stale data cannot pass.
    wire logic dqs_t_w = dqs_t_oe ? dqs_t_drv : (h_dqs_oe ? h_dqs : 1'b0);
    wire logic dqs_c_w = dqs_c_oe ? dqs_c_drv : (h_dqs_oe ? ~h_dqs : 1'b1);
    wire logic [7:0] dq_w = dq_oe_d ? dq_drv : (h_dq_oe ? h_dq : ~h_dq);
    dsw_ctrl u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ce_n(ce_n), .cle(cle), .ale(ale),
        .we_n(we_n), .read_strobe_true(rs_t), .read_strobe_comp(rs_c), .data_strobe_true(dqs_t_w),
        .data_strobe_true_drive(dqs_t_drv), .data_strobe_true_oe(dqs_t_oe), .data_strobe_comp(dqs_c_w),
        .data_strobe_comp_drive(dqs_c_drv), .data_strobe_comp_oe(dqs_c_oe), .data_bus(dq_w),
        .data_bus_drive(dq_drv), .data_bus_oe(dq_oe_d), .out_byte(out_byte), .out_take(out_take),
        .in_byte(in_byte), .in_valid(in_valid), .read_strobe_comp_active(rc_act),
        .data_strobe_comp_active(dc_act));
    dsw_host u_host (.sys_clk(sys_clk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .rs_t(rs_t),
        .rs_c(rs_c), .dqs_t(h_dqs), .dqs_oe(h_dqs_oe), .dq(h_dq), .dq_oe(h_dq_oe));
    always #2 sys_clk = ~sys_clk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Master holds the request until waitrequest is sampled low at a rising edge.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // Let one edge pass so a following call never re-raises a strobe in this step.
        @(posedge sys_clk);
    endtask

    // Complements count only in a double-rate mode and only with their own enable.
    function automatic logic [31:0] exp_act(input int m, input int e);
        return (m == 1 || m == 2) ? 32'(e) : 32'h0;
    endfunction

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Every taken byte must be the one offered; the offer then changes at random.
    always @(posedge sys_clk)
    begin
        if (dqs_t_oe === 1'b1)
        begin
            prev_s <= dqs_t_drv;
            if (dqs_t_drv !== prev_s)
                tog++;
            check("comp", {30'h0, dqs_c_oe, dqs_c_drv}, de[1] ? {30'h0, 1'b1, ~dqs_t_drv} : 32'h0);
        end
        if (out_take === 1'b1)
        begin
            takes++;
            check("out_data", {23'h0, dq_oe_d, dq_drv}, {23'h0, 1'b1, out_byte});
            out_byte <= 8'($urandom);
        end
        if (in_valid === 1'b1)
        begin
            if (valids == 0)
                first_in = in_byte;
            valids++;
        end
    end

    initial
    begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        out_byte = 8'h5A;
        prev_s = 1'b1;
        void'($urandom(69234));
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, DSW_OFF_CFG, 32'h0);
        check("cfg_reset", rd, 32'h0);
        bus(1'b0, DSW_OFF_CAP, 32'h0);
        check("cap", rd, 32'h3);
        bus(1'b0, 4'h2, 32'h0);
        check("unmapped", rd, 32'h0);
        // Differential enables in every mode, configured from single rate first.
        for (int m = 0; m < 3; m++)
            for (int e = 0; e < 4; e++)
            begin
                bus(1'b1, DSW_OFF_CFG, 32'((e << 2) | m));
                bus(1'b0, DSW_OFF_STAT, 32'h0);
                check("stat_comp", rd & 32'h3, exp_act(m, e));
                check("pin_comp", {30'h0, dc_act, rc_act}, exp_act(m, e));
            end
        // Each reset command in each double-rate variant.
        for (int m = 1; m < 3; m++)
            for (int c = 0; c < 3; c++)
            begin
                bus(1'b1, DSW_OFF_CFG, 32'(12 | m));
                bus(1'b1, DSW_OFF_CMD, 32'h1 << c);
                bus(1'b0, DSW_OFF_CFG, 32'h0);
                check("diff_keep", (rd >> 2) & 32'h3, (c == 0 && m == 1) ? 32'h0 : 32'h3);
            end
        // Bursts with independent random warmups; the first has none, the second pauses.
        for (int k = 0; k < 6; k++)
        begin
            ow = (k == 0) ? 0 : 1 + $urandom % 3;
            iw = (k == 0) ? 0 : $urandom % 4;
            nd = 2 * (1 + $urandom % 3);
            md = 1 + k % 2;
            de = k % 4;
            bus(1'b1, DSW_OFF_CFG, 32'((iw << 8) | (ow << 4) | (de << 2) | md));
            takes = 0;
            tog = 0;
            prev_s = 1'b1;
            u_host.out_burst(2 * ow + nd, (k == 1) ? 2 * ow + 1 : -1);
            check("takes", 32'(takes), 32'(nd));
            check("strobe_edges", 32'(tog), 32'(2 * ow + nd));
            valids = 0;
            first = 8'($urandom);
            u_host.in_burst(2 * iw + nd, first);
            check("valids", 32'(valids), 32'(nd));
            check("first_in", {24'h0, first_in}, {24'h0, first + 8'(2 * iw)});
        end
        print_verdict();
    end

    // Watchdog well beyond the thousand or so cycles the sequence needs.
    initial
    begin
        #200000;
        err_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
